// [design/stepper_current_sequencer.sv]
// Stepper phase-current sequencer with chopper and register slave.
`timescale 1ns/1ps
`include "stepper_consts.svh"
// What this block does
// (RULE1) Reset input high forces initial angle; low lets steps advance it.
// (RULE2) Angle monitor output is low while reset is asserted.
// (RULE3) Reset: 100% full and half, 71% quarter, at 45 degrees.
// (RULE4) Half step uses 100/0%; quarter uses 100/71/38/0%, either polarity.
// (RULE5) Each channel is regulated through charge, slow and fast decay.
// (RULE6) Reference direction: charge HS1+LS2, slow both LS, fast HS2+LS1.
// (RULE7) Opposite direction: charge HS2+LS1, slow both LS, fast HS1+LS2.
// (RULE8) Charge runs past the period boundary until the sense threshold.
// (RULE9) Reaching the target current ends charge and starts decay.
// (RULE10) Fast decay runs into the next period until the threshold.
// (RULE11) The mixed-decay threshold is fixed; nothing can change it.
// (RULE12) Chopper period is the oscillator frequency divided by sixteen.
// (RULE13) Host sets chopper near 70 kHz, within 50 to 100 kHz.
// (RULE14) Outside reset and standby, each step clock rising edge advances the angle; falling does not.
// (RULE15) Select pins: 00 standby, 01 full, 10 half, 11 quarter step.
// (RULE16) Direction high makes channel A lead; low makes channel B lead.
// (RULE17) Output enable low turns every bridge switch off.
// (RULE18) Angle monitor is high only at the initial angle.
// (RULE19) Step clock and control inputs are synchronised before use.
module stepper_current_sequencer (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic STEP_CLK_I,
  input wire logic ANGLE_RESET_I,
  input wire logic ROT_DIR_I,
  input wire logic RES_SEL_1_I,
  input wire logic RES_SEL_2_I,
  input wire logic OUT_ENABLE_I,
  input wire logic SENSE_A_I,
  input wire logic SENSE_B_I,
  input wire logic MIX_DECAY_A_I,
  input wire logic MIX_DECAY_B_I,
  output logic ANGLE_MON_O,
  output logic [3:0] BRIDGE_A_O,
  output logic [3:0] BRIDGE_B_O,
  output logic [1:0] LEVEL_A_O,
  output logic [1:0] LEVEL_B_O,
  output logic NEG_A_O,
  output logic NEG_B_O,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------

  // Returns {negative, level} for a phase at the given angle index.
  function automatic logic [2:0] phase_cur(
    input logic [3:0] idx,
    input stepper_pkg::res_mode_t m
  );
    logic [2:0] d;
    stepper_pkg::cur_lvl_t l;
    d = idx[2:0];
    if (d > 3'h4)
      d = 3'(4'h8 - {1'b0, d});
    l = stepper_pkg::LVL_0;
    unique case (m)
      stepper_pkg::MODE_FULL: l = stepper_pkg::LVL_100;
      stepper_pkg::MODE_HALF:
        l = (d == 3'h4) ? stepper_pkg::LVL_0 : stepper_pkg::LVL_100;
      stepper_pkg::MODE_QUARTER:
      begin
        unique case (d)
          3'h0, 3'h1: l = stepper_pkg::LVL_100;
          3'h2: l = stepper_pkg::LVL_71;
          3'h3: l = stepper_pkg::LVL_38;
          default: l = stepper_pkg::LVL_0;
        endcase
      end
      stepper_pkg::MODE_STBY: l = stepper_pkg::LVL_0;
    endcase
    return {(idx > 4'h4) && (idx < 4'hC), l}; // [RULE4]
  endfunction : phase_cur

  // Chopper sequence of one channel for the next cycle.
  function automatic stepper_pkg::chop_t chop_step(
    input stepper_pkg::chop_t cur,
    input logic run,
    input logic ps,
    input logic sense,
    input logic mdec
  );
    stepper_pkg::chop_t n;
    n = cur;
    unique case (cur)
      stepper_pkg::CH_OFF: n = ps ? stepper_pkg::CH_CHARGE : cur;
      // Charge ignores the period boundary until the target is reached.
      stepper_pkg::CH_CHARGE:
        n = sense ? stepper_pkg::CH_FAST : cur; // [RULE8] [RULE9]
      // Fast decay runs on across periods until the fixed threshold trips.
      stepper_pkg::CH_FAST:
        if (mdec) // [RULE10] [RULE11]
          n = ps ? stepper_pkg::CH_CHARGE : stepper_pkg::CH_SLOW;
      stepper_pkg::CH_SLOW: n = ps ? stepper_pkg::CH_CHARGE : cur;
    endcase
    return run ? n : stepper_pkg::CH_OFF; // [RULE5]
  endfunction : chop_step

  // Switch pattern {hs_first, hs_second, ls_first, ls_second}.
  function automatic logic [3:0] bridge(
    input stepper_pkg::chop_t m,
    input logic neg
  );
    logic [3:0] b;
    b = 4'h0;
    unique case (m)
      stepper_pkg::CH_CHARGE: b = neg ? 4'h6 : 4'h9; // [RULE6] [RULE7]
      stepper_pkg::CH_SLOW: b = 4'h3; // [RULE6] [RULE7]
      stepper_pkg::CH_FAST: b = neg ? 4'h9 : 4'h6; // [RULE6] [RULE7]
      stepper_pkg::CH_OFF: b = 4'h0;
    endcase
    return b;
  endfunction : bridge

  function automatic stepper_pkg::reg_sel_t decode(input logic [7:0] a);
    stepper_pkg::reg_sel_t s;
    s = stepper_pkg::SEL_NONE;
    if (a[7:2] == `OSC_DIV_OFS)
      s = stepper_pkg::SEL_DIV;
    else if (a[7:2] == `STATUS_OFS)
      s = stepper_pkg::SEL_STAT;
    return s;
  endfunction : decode

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------

  stepper_pkg::state_t st_ff;
  stepper_pkg::state_t nxt_st;
  stepper_pkg::res_mode_t mode;
  logic rst_on;
  logic rise;
  logic run;
  logic tick;
  logic [3:0] stp;
  logic [2:0] pa;
  logic [2:0] pb;

  assign mode = stepper_pkg::res_mode_t'({st_ff.s2[`SY_M1],
                                           st_ff.s2[`SY_M2]}); // [RULE15]
  assign rst_on = st_ff.s2[`SY_RST];
  assign rise = st_ff.s2[`SY_STEP] && !st_ff.step_prev; // [RULE14]
  assign run = mode != stepper_pkg::MODE_STBY;
  assign tick = ({1'b0, st_ff.osc_cnt} + 17'h1) >= {1'b0, st_ff.osc_div};
  assign stp = (mode == stepper_pkg::MODE_FULL) ? 4'h4 :
               (mode == stepper_pkg::MODE_HALF) ? 4'h2 : 4'h1;

  always_comb
  begin
    nxt_st = st_ff;
    // Only the second stage feeds any logic.
    nxt_st.s1 = {MIX_DECAY_B_I, MIX_DECAY_A_I, SENSE_B_I, SENSE_A_I,
                 OUT_ENABLE_I, RES_SEL_2_I, RES_SEL_1_I, ROT_DIR_I,
                 ANGLE_RESET_I, STEP_CLK_I}; // [RULE19]
    nxt_st.s2 = st_ff.s1; // [RULE19]
    nxt_st.step_prev = st_ff.s2[`SY_STEP];

    // Electrical angle in 22.5 degree units.
    if (rst_on)
      nxt_st.angle = `ANGLE_INIT; // [RULE1] [RULE3]
    else if (rise && run)
    begin
      if (st_ff.s2[`SY_DIR])
        nxt_st.angle = st_ff.angle + stp; // [RULE14] [RULE16]
      else
        nxt_st.angle = st_ff.angle - stp; // [RULE16]
    end
    nxt_st.mon = !rst_on && (nxt_st.angle == `ANGLE_INIT); // [RULE2] [RULE18]
    pa = phase_cur(nxt_st.angle, mode); // [RULE3] [RULE4]
    pb = phase_cur(nxt_st.angle - 4'h4, mode);
    nxt_st.neg_a = pa[2];
    nxt_st.lvl_a = stepper_pkg::cur_lvl_t'(pa[1:0]);
    nxt_st.neg_b = pb[2];
    nxt_st.lvl_b = stepper_pkg::cur_lvl_t'(pb[1:0]);

    // Oscillator and chopper period; stopped in standby.
    nxt_st.pstart = 1'b0;
    if (!run)
    begin
      nxt_st.osc_cnt = 16'h0;
      nxt_st.tick_cnt = 4'h0;
    end
    else if (tick)
    begin
      nxt_st.osc_cnt = 16'h0;
      nxt_st.tick_cnt = st_ff.tick_cnt + 4'h1;
      nxt_st.pstart = st_ff.tick_cnt == `CHOP_DIV; // [RULE12]
    end
    else
      nxt_st.osc_cnt = st_ff.osc_cnt + 16'h1;

    nxt_st.run = run;
    nxt_st.en_on = run && st_ff.s2[`SY_EN];
    nxt_st.chop_a = chop_step(st_ff.chop_a, run, st_ff.pstart,
                              st_ff.s2[`SY_SNA], st_ff.s2[`SY_MDA]);
    nxt_st.chop_b = chop_step(st_ff.chop_b, run, st_ff.pstart,
                              st_ff.s2[`SY_SNB], st_ff.s2[`SY_MDB]);
    nxt_st.br_a = nxt_st.en_on ? bridge(nxt_st.chop_a, nxt_st.neg_a)
                               : 4'h0; // [RULE17] [RULE15]
    nxt_st.br_b = nxt_st.en_on ? bridge(nxt_st.chop_b, nxt_st.neg_b)
                               : 4'h0; // [RULE17] [RULE15]

    // Register slave: write path.
    if (st_ff.bvalid && BREADY_I)
      nxt_st.bvalid = 1'b0;
    if (AWVALID_I && st_ff.awready)
    begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = AWADDR_I;
    end
    if (WVALID_I && st_ff.wready)
    begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = WDATA_I;
      nxt_st.w_strb = WSTRB_I;
    end
    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid)
    begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `AXI_OKAY;
      unique case (decode(st_ff.aw_addr))
        stepper_pkg::SEL_DIV:
        begin
          // The host picks the oscillator rate here. [RULE13]
          if (st_ff.w_strb[0])
            nxt_st.osc_div[7:0] = st_ff.w_data[7:0];
          if (st_ff.w_strb[1])
            nxt_st.osc_div[15:8] = st_ff.w_data[15:8];
        end
        stepper_pkg::SEL_STAT: nxt_st.bresp = `AXI_OKAY;
        default: nxt_st.bresp = `AXI_SLVERR;
      endcase
    end
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;

    // Register slave: read path.
    if (st_ff.rvalid && RREADY_I)
      nxt_st.rvalid = 1'b0;
    if (ARVALID_I && st_ff.arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `AXI_OKAY;
      nxt_st.rdata = 32'h0;
      unique case (decode(ARADDR_I))
        stepper_pkg::SEL_DIV: nxt_st.rdata = {16'h0, st_ff.osc_div};
        stepper_pkg::SEL_STAT:
          nxt_st.rdata = {21'h0, st_ff.chop_b, st_ff.chop_a, st_ff.mon,
                          mode, st_ff.angle};
        default: nxt_st.rresp = `AXI_SLVERR;
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      st_ff <= '0;
      st_ff.angle <= `ANGLE_INIT;
      st_ff.osc_div <= `OSC_DIV_RST;
      st_ff.chop_a <= stepper_pkg::CH_OFF;
      st_ff.chop_b <= stepper_pkg::CH_OFF;
      st_ff.lvl_a <= stepper_pkg::LVL_0;
      st_ff.lvl_b <= stepper_pkg::LVL_0;
    end
    else
      st_ff <= nxt_st;
  end

  assign ANGLE_MON_O = st_ff.mon;
  assign BRIDGE_A_O = st_ff.br_a;
  assign BRIDGE_B_O = st_ff.br_b;
  assign LEVEL_A_O = st_ff.lvl_a;
  assign LEVEL_B_O = st_ff.lvl_b;
  assign NEG_A_O = st_ff.neg_a;
  assign NEG_B_O = st_ff.neg_b;
  assign AWREADY_O = st_ff.awready;
  assign WREADY_O = st_ff.wready;
  assign BRESP_O = st_ff.bresp;
  assign BVALID_O = st_ff.bvalid;
  assign ARREADY_O = st_ff.arready;
  assign RDATA_O = st_ff.rdata;
  assign RRESP_O = st_ff.rresp;
  assign RVALID_O = st_ff.rvalid;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);

  // Counts oscillator ticks between period starts.
  logic [4:0] ticks_seen;
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ticks_seen <= 5'h0;
    else if (st_ff.pstart)
      ticks_seen <= 5'h1;
    else if (st_ff.osc_cnt == 16'h0 && st_ff.run && ticks_seen != 5'h1F)
      ticks_seen <= ticks_seen + 5'h1;
  end

  a_reset_angle: assert property ( // [RULE1]
    rst_on |=> st_ff.angle == `ANGLE_INIT)
    else $error("angle not at initial position during reset");
  a_mon_reset: assert property ( // [RULE2]
    rst_on |=> !ANGLE_MON_O)
    else $error("angle monitor high during reset");
  a_reset_quarter: assert property ( // [RULE3]
    rst_on && mode == stepper_pkg::MODE_QUARTER |=>
      LEVEL_A_O == 2'h1 && LEVEL_B_O == 2'h1)
    else $error("reset current not 71 percent in quarter step");
  a_half_levels: assert property ( // [RULE4]
    $past(mode) == stepper_pkg::MODE_HALF |->
      LEVEL_A_O == 2'h0 || LEVEL_A_O == 2'h3)
    else $error("half step level outside 100 and 0 percent");
  a_charge_fwd: assert property ( // [RULE6]
    st_ff.en_on && st_ff.chop_a == stepper_pkg::CH_CHARGE && !NEG_A_O
      |-> BRIDGE_A_O == 4'h9)
    else $error("wrong charge pattern, reference direction");
  a_fast_rev: assert property ( // [RULE7]
    st_ff.en_on && st_ff.chop_a == stepper_pkg::CH_FAST && NEG_A_O
      |-> BRIDGE_A_O == 4'h9)
    else $error("wrong fast decay pattern, opposite direction");
  a_charge_hold: assert property ( // [RULE8]
    st_ff.chop_a == stepper_pkg::CH_CHARGE && !st_ff.s2[`SY_SNA]
      ##1 st_ff.run |-> st_ff.chop_a == stepper_pkg::CH_CHARGE)
    else $error("charge ended before sense threshold");
  a_charge_exit: assert property ( // [RULE9]
    st_ff.chop_a == stepper_pkg::CH_CHARGE && st_ff.s2[`SY_SNA]
      ##1 st_ff.run |-> st_ff.chop_a == stepper_pkg::CH_FAST)
    else $error("charge did not enter decay at target");
  a_fast_hold: assert property ( // [RULE10]
    st_ff.chop_a == stepper_pkg::CH_FAST && !st_ff.s2[`SY_MDA]
      && st_ff.pstart ##1 st_ff.run
      |-> st_ff.chop_a == stepper_pkg::CH_FAST)
    else $error("fast decay stopped at period boundary");
  a_chop_period: assert property ( // [RULE12]
    st_ff.pstart && $past(st_ff.run, 40) |-> ticks_seen == 5'h10)
    else $error("chopper period is not sixteen oscillator ticks");
  a_mon_init: assert property ( // [RULE18]
    ANGLE_MON_O |-> st_ff.angle == `ANGLE_INIT && !$past(rst_on))
    else $error("monitor high away from initial angle");
  a_step_quarter: assert property ( // [RULE14]
    rise && !rst_on && st_ff.s2[`SY_DIR] &&
      mode == stepper_pkg::MODE_QUARTER |=>
      st_ff.angle == $past(st_ff.angle) + 4'h1)
    else $error("quarter step did not advance one position");
  a_enable_off: assert property ( // [RULE17]
    !st_ff.s2[`SY_EN] |=> BRIDGE_A_O == 4'h0 && BRIDGE_B_O == 4'h0)
    else $error("bridge driven while output enable low");
  a_standby_off: assert property ( // [RULE15]
    mode == stepper_pkg::MODE_STBY |=> ##1
      st_ff.chop_a == stepper_pkg::CH_OFF && BRIDGE_B_O == 4'h0)
    else $error("standby left chopper running");

endmodule : stepper_current_sequencer

// [common/stepper_consts.svh]
// Offsets, reset values, bit positions and timing counts of the sequencer.
`ifndef STEPPER_CONSTS_SVH
`define STEPPER_CONSTS_SVH
`define OSC_DIV_OFS 6'h00
`define STATUS_OFS 6'h01
`define CLK_FREQ_KHZ 100000
`define OSC_FREQ_KHZ 1120
`define OSC_DIV_RST 16'(`CLK_FREQ_KHZ / `OSC_FREQ_KHZ)
`define CHOP_DIV 4'hF
`define ANGLE_INIT 4'h2
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define SY_STEP 0
`define SY_RST 1
`define SY_DIR 2
`define SY_M1 3
`define SY_M2 4
`define SY_EN 5
`define SY_SNA 6
`define SY_SNB 7
`define SY_MDA 8
`define SY_MDB 9
`endif

// [common/stepper_pkg.sv]
// Types shared by the stepper current sequencer.
package stepper_pkg;
  typedef enum logic [1:0] {MODE_STBY, MODE_FULL, MODE_HALF, MODE_QUARTER}
    res_mode_t;
  typedef enum logic [1:0] {LVL_100, LVL_71, LVL_38, LVL_0} cur_lvl_t;
  typedef enum logic [1:0] {CH_OFF, CH_CHARGE, CH_FAST, CH_SLOW} chop_t;
  typedef enum logic [1:0] {SEL_DIV, SEL_STAT, SEL_NONE} reg_sel_t;
  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
    logic step_prev;
    logic [3:0] angle;
    logic mon;
    logic [15:0] osc_div;
    logic [15:0] osc_cnt;
    logic [3:0] tick_cnt;
    logic pstart;
    logic run;
    logic en_on;
    chop_t chop_a;
    chop_t chop_b;
    cur_lvl_t lvl_a;
    cur_lvl_t lvl_b;
    logic neg_a;
    logic neg_b;
    logic [3:0] br_a;
    logic [3:0] br_b;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage : stepper_pkg

// [test/host_model.sv]
// Host controller model driving the step clock and motor control pins.
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output logic step_o,
  output logic angle_reset_o,
  output logic rot_dir_o,
  output logic sel_1_o,
  output logic sel_2_o,
  output logic enable_o
);
  initial
  begin
    step_o = 1'b0;
    angle_reset_o = 1'b0;
    rot_dir_o = 1'b0;
    sel_1_o = 1'b0;
    sel_2_o = 1'b0;
    enable_o = 1'b0;
  end

  // One rising edge per step; high for two clocks, then low for at least six.
  task automatic step();
    @(posedge clk_i);
    step_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    step_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : step

  // Sets the level pins and waits until the block has taken them in.
  task automatic pins(input logic r, d, s1, s2, e);
    @(posedge clk_i);
    angle_reset_o <= r;
    rot_dir_o <= d;
    sel_1_o <= s1;
    sel_2_o <= s2;
    enable_o <= e;
    repeat (5) @(posedge clk_i);
  endtask : pins
endmodule : host_model

// [test/stepper_current_sequencer_test.sv]
// Self-checking testbench of the stepper current sequencer.
`timescale 1ns/1ps
`include "stepper_consts.svh"
module stepper_current_sequencer_test;
  localparam logic [7:0] A_DIV = {`OSC_DIV_OFS, 2'b00};
  localparam logic [7:0] A_ST = {`STATUS_OFS, 2'b00};
  localparam logic [15:0] LQ = 16'h1B90;
  logic clk, rst_b, step, arst, dir, s1, s2, en;
  logic sns_a, sns_b, mix_a, mix_b, awv, wv, bre, arv, rre;
  logic mon, nga, ngb, awr, wdr, bv, arr, rv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [3:0] ws, bra, brb;
  logic [1:0] lva, lvb, br, rr;
  int mismatches, checks_done;

  stepper_current_sequencer stepper_current_sequencer_inst (
    .CLOCK_I(clk), .RST_B_I(rst_b), .STEP_CLK_I(step),
    .ANGLE_RESET_I(arst), .ROT_DIR_I(dir), .RES_SEL_1_I(s1),
    .RES_SEL_2_I(s2), .OUT_ENABLE_I(en), .SENSE_A_I(sns_a),
    .SENSE_B_I(sns_b), .MIX_DECAY_A_I(mix_a), .MIX_DECAY_B_I(mix_b),
    .ANGLE_MON_O(mon), .BRIDGE_A_O(bra), .BRIDGE_B_O(brb),
    .LEVEL_A_O(lva), .LEVEL_B_O(lvb), .NEG_A_O(nga), .NEG_B_O(ngb),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wdr), .BRESP_O(br),
    .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rr), .RVALID_O(rv),
    .RREADY_I(rre));

  host_model host_model_inst (
    .clk_i(clk), .step_o(step), .angle_reset_o(arst), .rot_dir_o(dir),
    .sel_1_o(s1), .sel_2_o(s2), .enable_o(en));

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      ad = ad | (awr === 1'b1);
      dd = dd | (wdr === 1'b1);
      awv <= !ad;
      wv <= !dd;
    end
    while (bv !== 1'b1)
      @(posedge clk);
    chk(br, e);
    bre <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do
      @(posedge clk);
    while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1)
      @(posedge clk);
    d = rdat;
    chk(rr, e);
    rre <= 1'b0;
  endtask : rd

  // Walks channel A through charge, fast and slow decay.
  task automatic chop(input logic [3:0] c, f);
    int n;
    n = 0;
    @(posedge clk);
    sns_a <= 1'b0;
    mix_a <= 1'b0;
    while (bra !== c && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(bra, c);
    repeat (40) @(posedge clk);
    chk(bra, c);
    sns_a <= 1'b1;
    repeat (6) @(posedge clk);
    chk(bra, f);
    sns_a <= 1'b0;
    repeat (40) @(posedge clk);
    chk(bra, f);
    mix_a <= 1'b1;
    n = 0;
    while (bra !== 4'h3 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    chk(bra, 4'h3);
  endtask : chop

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    int n;
    clk = 1'b0;
    rst_b = 1'b0;
    {sns_a, mix_a, awv, wv, bre, arv, rre} = '0;
    {sns_b, mix_b} = 2'b11;
    {awa, ara, wd, ws} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(A_DIV, `AXI_OKAY);
    chk(d, 32'(`OSC_DIV_RST));
    rd(8'h08, `AXI_SLVERR);
    chk(d, 32'h0);
    wr(8'h08, 32'h5, `AXI_SLVERR);
    wr(A_ST, 32'hFF, `AXI_OKAY);
    rd(A_ST, `AXI_OKAY);
    chk(d[3:0], 4'h2);
    wr(A_DIV, 32'h2, `AXI_OKAY);
    rd(A_DIV, `AXI_OKAY);
    chk(d, 32'h2);
    for (int m = 1; m < 4; m++)
    begin
      host_model_inst.pins(1'b1, 1'b1, m[1], m[0], 1'b0);
      chk(mon, 0);
      chk(lva, (m == 3) ? 1 : 0);
      chk(lvb, (m == 3) ? 1 : 0);
      rd(A_ST, `AXI_OKAY);
      chk(d[5:4], m);
      host_model_inst.pins(1'b0, 1'b1, m[1], m[0], 1'b0);
      chk(mon, 1);
      host_model_inst.step();
      rd(A_ST, `AXI_OKAY);
      chk(d[3:0], 2 + (8 >> m));
      chk(mon, 0);
      if (m == 2)
        chk({lva, lvb}, 4'hC);
    end
    for (int i = 4; i < 9; i++)
    begin
      host_model_inst.step();
      chk(lva, LQ[2 * (i & 7) +: 2]);
      chk(lvb, LQ[2 * ((i - 4) & 7) +: 2]);
    end
    chk(nga, 1);
    host_model_inst.pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    repeat (6) host_model_inst.step();
    rd(A_ST, `AXI_OKAY);
    chk(d[3:0], 4'h2);
    chk(mon, 1);
    host_model_inst.pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    host_model_inst.step();
    rd(A_ST, `AXI_OKAY);
    chk(d[5:0], 6'h02);
    chk({bra, brb}, 8'h00);
    host_model_inst.pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    host_model_inst.pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    chop(4'h9, 4'h6);
    host_model_inst.step();
    chop(4'h6, 4'h9);
    sns_a <= 1'b1;
    while (bra !== 4'h6)
      @(posedge clk);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bra === 4'h6);
    while (bra !== 4'h6)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, 32);
    host_model_inst.pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk({bra, brb}, 8'h00);
    results();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : stepper_current_sequencer_test
